// [qdc_control.sv]
// serial control of a four channel 8-bit converter with stored settings
// Summary of operation
// - four channels, each an 8-bit setting
// - power-up loads stored settings, no host action
// - stored setting per channel, outputs steady meanwhile
// - temporary setting leaves storage untouched
// - address and data arrive LSB first
// - first one sampled starts a frame
// - serial input sampled on rising clock edges
// - two address bits choose channel one..four
// - ignore serial input while not selected
// - serial output high impedance when unused
// - ready low for erase/write time after falling edge
// - select low restores stored settings, output off
// - start, two address, eight data; update after
// - old setting shifted out LSB first, stored setting kept unless the frame commits with the program strobe high
// - programming: ready low, input ignored, no output
`timescale 1ns/1ps
module qdc_control #(
	parameter int          BUSY_CYCLES = qdc_pkg::ERASE_WRITE_CYCLES,
	parameter logic [31:0] STORE_INIT  = qdc_pkg::STORE_INIT
) (
	input  wire logic                      clock_in,
	input  wire logic                      reset_n_in,
	input  wire logic                      serial_clock_in,
	input  wire logic                      chip_select_in,
	input  wire logic                      serial_in,
	input  wire logic                      program_strobe_in,
	output logic                           serial_out_out,
	output logic                           serial_out_oe_n_out,
	output logic                           ready_out,
	output logic [4*qdc_pkg::DATA_BITS-1:0] channel_setting_out
);
	import qdc_pkg::*;

	if (BUSY_CYCLES < 1) begin : g_check
		$error("BUSY_CYCLES must be at least one");
	end

	qdc_store_if store_bus ();

	qdc_store #(
		.INIT (STORE_INIT)
	) u_store (
		.clock_in   (clock_in),
		.reset_n_in (reset_n_in),
		.port       (store_bus.store)
	);

	qdc_state_t state;
	qdc_byte_t  ctrl [CHANNELS];
	qdc_byte_t  shift;
	qdc_addr_t  addr;
	logic [2:0] bit_cnt;
	logic [2:0] restore_idx;
	logic       sclk_q;
	logic       busy;
	logic       wait_fall;
	logic [31:0] busy_cnt;

	wire logic       sclk_rise  = serial_clock_in & ~sclk_q;
	wire logic       sclk_fall  = ~serial_clock_in & sclk_q;
	wire logic       take_edge  = sclk_rise & chip_select_in & ~busy;
	wire qdc_addr_t  next_addr  = {serial_in, addr[1]};
	wire qdc_byte_t  next_shift = {serial_in, shift[7:1]};
	wire logic       commit     = take_edge & (state == ST_DONE);
	wire logic       do_program = commit & program_strobe_in;
	wire logic       in_frame   = (state == ST_ADDR) | (state == ST_DATA) | (state == ST_DONE);
	wire logic       restoring  = (state == ST_RESTORE);
	wire qdc_addr_t  restore_ch = qdc_addr_t'(restore_idx - 3'h1);

	// storage access: read for restore, write on a programming commit
	assign store_bus.ctrl.rd_addr = restore_idx[1:0];
	assign store_bus.ctrl.wr_en   = do_program;
	assign store_bus.ctrl.wr_addr = addr;
	assign store_bus.ctrl.wr_data = shift;

	generate
		for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
			assign channel_setting_out[g*DATA_BITS +: DATA_BITS] = ctrl[g];
		end
	endgenerate

	assign serial_out_out      = shift[0];
	assign serial_out_oe_n_out = ~(chip_select_in & ~busy);
	assign ready_out           = ~(busy | (in_frame & program_strobe_in & chip_select_in));

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= serial_clock_in;
		end
	end

	// frame sequencing; select low forces a restore sweep
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state       <= ST_RESTORE;
			restore_idx <= 3'h0;
			bit_cnt     <= 3'h0;
			addr        <= '0;
		end else if (!chip_select_in) begin
			state       <= ST_RESTORE;
			restore_idx <= (restoring && restore_idx != RESTORE_LAST) ? restore_idx + 3'h1 : 3'h0;
		end else begin
			case (state)
				ST_RESTORE: begin
					restore_idx <= restore_idx + 3'h1;
					if (restore_idx == RESTORE_LAST) begin
						restore_idx <= 3'h0;
						state       <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (take_edge && serial_in) begin
						state   <= ST_ADDR;
						bit_cnt <= 3'h0;
					end
				end
				ST_ADDR: begin
					if (take_edge) begin
						addr    <= next_addr;
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt[0]) begin
							state   <= ST_DATA;
							bit_cnt <= 3'h0;
						end
					end
				end
				ST_DATA: begin
					if (take_edge) begin
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == LAST_DATA_IDX) begin
							state <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					if (take_edge) begin
						state <= ST_GAP;
					end
				end
				ST_GAP: begin
					if (take_edge) begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// shift register: old setting out, new setting in
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			shift <= CTRL_RESET;
		end else if (!chip_select_in) begin
			shift <= CTRL_RESET;
		end else if (take_edge && state == ST_ADDR && bit_cnt[0]) begin
			shift <= ctrl[next_addr];
		end else if (take_edge && state == ST_DATA) begin
			shift <= next_shift;
		end else if (state == ST_IDLE) begin
			shift <= CTRL_RESET;
		end
	end

	// control registers drive the outputs; loaded by a restore, or on the edge after the last data bit
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < CHANNELS; i++) begin
				ctrl[i] <= CTRL_RESET;
			end
		end else if (restoring && restore_idx != 3'h0) begin
			ctrl[restore_ch] <= store_bus.ctrl.rd_data;
		end else if (commit) begin
			ctrl[addr] <= shift;
		end
	end

	// erase/write timing, started by the first falling edge after commit
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			busy      <= 1'b0;
			wait_fall <= 1'b0;
			busy_cnt  <= 32'h0;
		end else if (do_program) begin
			busy      <= 1'b1;
			wait_fall <= 1'b1;
			busy_cnt  <= 32'h0;
		end else if (wait_fall) begin
			wait_fall <= ~sclk_fall;
		end else if (busy) begin
			busy_cnt <= busy_cnt + 32'h1;
			if (busy_cnt == 32'(BUSY_CYCLES - 1)) begin
				busy <= 1'b0;
			end
		end
	end
endmodule

// [qdc_pkg.sv]
// shared constants and types for the quad converter serial control
package qdc_pkg;
	localparam int CHANNELS         = 4;
	localparam int DATA_BITS        = 8;
	localparam int ADDR_BITS        = 2;
	localparam int CLOCK_PERIOD_NS  = 40;
	localparam int ERASE_WRITE_TIME_NS = 4000000;
	localparam int ERASE_WRITE_CYCLES  = ERASE_WRITE_TIME_NS / CLOCK_PERIOD_NS;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [31:0] STORE_INIT = 32'h80808080;
	localparam logic [2:0] LAST_DATA_IDX = 3'h7;
	localparam logic [2:0] RESTORE_LAST  = 3'h4;

	typedef logic [DATA_BITS-1:0] qdc_byte_t;
	typedef logic [ADDR_BITS-1:0] qdc_addr_t;

	typedef enum logic [2:0] {
		ST_RESTORE,
		ST_IDLE,
		ST_ADDR,
		ST_DATA,
		ST_DONE,
		ST_GAP
	} qdc_state_t;
endpackage

// [qdc_store_if.sv]
// carrier between control logic and setting storage
`timescale 1ns/1ps
interface qdc_store_if;
	import qdc_pkg::*;
	logic      wr_en;
	qdc_addr_t wr_addr;
	qdc_byte_t wr_data;
	qdc_addr_t rd_addr;
	qdc_byte_t rd_data;
	modport ctrl  (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// [qdc_store.sv]
// persistent storage of the four channel settings
`timescale 1ns/1ps
module qdc_store #(
	parameter logic [31:0] INIT = qdc_pkg::STORE_INIT
) (
	input  wire logic     clock_in,
	input  wire logic     reset_n_in,
	qdc_store_if.store    port
);
	import qdc_pkg::*;

	qdc_byte_t mem [CHANNELS];

	// contents model the retained cells; they survive reset
	initial begin
		for (int i = 0; i < CHANNELS; i++) begin
			mem[i] = INIT[i*DATA_BITS +: DATA_BITS];
		end
	end

	always_ff @(posedge clock_in) begin
		if (port.wr_en) begin
			mem[port.wr_addr] <= port.wr_data;
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			port.rd_data <= CTRL_RESET;
		end else begin
			port.rd_data <= mem[port.rd_addr];
		end
	end
endmodule

// [qdc_control_assertions.sv]
// port level checks of the quad converter serial control
`timescale 1ns/1ps
module qdc_control_assertions (
	input  wire logic        clock_in,
	input  wire logic        reset_n_in,
	input  wire logic        serial_clock_in,
	input  wire logic        chip_select_in,
	input  wire logic        serial_in,
	input  wire logic        program_strobe_in,
	input  wire logic        serial_out_out,
	input  wire logic        serial_out_oe_n_out,
	input  wire logic        ready_out,
	input  wire logic [31:0] channel_setting_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);
	sequence s_busy; !ready_out [*8]; endsequence
	sequence s_off; !chip_select_in [*8]; endsequence
	sequence s_sel3; chip_select_in && $past(chip_select_in) && $past(chip_select_in, 2); endsequence
	property p_oe_off; !chip_select_in |-> serial_out_oe_n_out; endproperty
	a_oe_off: assert property (p_oe_off) else $error("output enabled while deselected");
	property p_oe_on; chip_select_in && ready_out |-> !serial_out_oe_n_out; endproperty
	a_oe_on: assert property (p_oe_on) else $error("output off while selected");
	property p_busy_quiet; !ready_out && !program_strobe_in |-> serial_out_oe_n_out; endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("output driven while busy");
	property p_busy_min; $fell(ready_out) |-> s_busy; endproperty
	a_busy_min: assert property (p_busy_min) else $error("busy too short");
	property p_busy_max; $fell(ready_out) |-> ##[1:200] ready_out; endproperty
	a_busy_max: assert property (p_busy_max) else $error("busy never ends");
	property p_off_hold; s_off |-> $stable(channel_setting_out); endproperty
	a_off_hold: assert property (p_off_hold) else $error("setting moved while deselected");
	property p_out_edge;
		chip_select_in && $past(chip_select_in) && ready_out && $past(ready_out) && $changed(serial_out_out)
		|-> ($past(serial_clock_in) && !$past(serial_clock_in, 2)) || ($past(serial_clock_in, 2) && !$past(serial_clock_in, 3));
	endproperty
	a_out_edge: assert property (p_out_edge) else $error("read bit not on serial edge");
	property p_chan_edge;
		s_sel3 ##0 $changed(channel_setting_out)
		|-> ($past(serial_clock_in) && !$past(serial_clock_in, 2)) || ($past(serial_clock_in, 2) && !$past(serial_clock_in, 3));
	endproperty
	a_chan_edge: assert property (p_chan_edge) else $error("setting moved off serial edge");
endmodule
bind qdc_control qdc_control_assertions chk (.clock_in, .reset_n_in, .serial_clock_in, .chip_select_in, .serial_in,
	.program_strobe_in, .serial_out_out, .serial_out_oe_n_out, .ready_out, .channel_setting_out);

// [qdc_host_model.sv]
// host side model driving the three wire serial bus
`timescale 1ns/1ps
module qdc_host_model (
	input  wire logic clock_in,
	input  wire logic sdo_in,
	output logic      sclk_out = 1'h0,
	output logic      cs_out = 1'h0,
	output logic      sdi_out = 1'h0,
	output logic      program_strobe_out = 1'h0
);
	task automatic select(input logic v);
		@(posedge clock_in) cs_out <= v;
		repeat (10) @(posedge clock_in);
	endtask
	// clock stands still outside frames; with 13 edges, second to last edge commits, last edge is the gap
	task automatic frame(input logic [1:0] addr, input logic [7:0] data, input logic program_strobe, input int edges,
		output logic [7:0] rd);
		logic [12:0] bits;
		bits = {2'h0, data, addr, 1'h1};
		for (int i = 0; i < edges; i++) begin
			@(posedge clock_in) sdi_out <= bits[i];
			if (i == 10) program_strobe_out <= program_strobe;
			repeat (2) @(posedge clock_in);
			if (i > 2 && i < 11) rd[i-3] = sdo_in;
			sclk_out <= 1'h1;
			repeat (2) @(posedge clock_in);
			sclk_out <= 1'h0;
		end
		@(posedge clock_in) program_strobe_out <= 1'h0;
		sdi_out <= ~sdi_out;
	endtask
endmodule

// [qdc_control_tb.sv]
// self checking bench of the quad converter serial control
`timescale 1ns/1ps
module qdc_control_tb;
	import qdc_pkg::*;
	logic        clock_in = 1'h0;
	logic        reset_n_in = 1'h0;
	logic        sclk, cs, sdi, program_strobe, sdo_raw, oe_n, ready;
	logic [31:0] chans, exp;
	logic [7:0]  rd, val;
	wire         sdo = oe_n ? 1'bz : sdo_raw;
	int          num_errors = 0;
	int          samples_checked = 0;
	qdc_control #(.BUSY_CYCLES(20)) dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .serial_clock_in(sclk),
		.chip_select_in(cs), .serial_in(sdi), .program_strobe_in(program_strobe), .serial_out_out(sdo_raw),
		.serial_out_oe_n_out(oe_n), .ready_out(ready), .channel_setting_out(chans));
	qdc_host_model host (.clock_in(clock_in), .sdo_in(sdo), .sclk_out(sclk), .cs_out(cs), .sdi_out(sdi),
		.program_strobe_out(program_strobe));
	initial begin
		forever #20 clock_in = ~clock_in;
	end
	task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic end_sim;
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic t_temp;
		exp = STORE_INIT;
		host.select(1'h1);
		for (int i = 0; i < 5; i++) begin
			val = 8'h31 + 8'(i);
			host.frame(2'(i % 4), val, 1'h0, 13, rd);
			check("read", {24'h0, exp[(i%4)*8+:8]}, {24'h0, rd});
			exp[(i%4)*8+:8] = val;
			check("channels", exp, chans);
		end
		host.select(1'h0);
		check("line", 32'h0 | 1'bz, {31'h0, sdo});
		host.select(1'h1);
		check("restored", STORE_INIT, chans);
	endtask
	task automatic t_program_strobe;
		int n;
		host.frame(2'h3, 8'hA5, 1'h1, 13, rd);
		check("busy", 32'h0, {31'h0, ready});
		check("busy line", 32'h0 | 1'bz, {31'h0, sdo});
		n = 0;
		while (ready !== 1'h1 && n < 100) begin
			@(posedge clock_in);
			n++;
		end
		check("ready", 32'h1, {31'h0, ready});
		host.select(1'h0);
		host.select(1'h1);
		exp = {8'hA5, STORE_INIT[23:0]};
		check("stored", exp, chans);
	endtask
	task automatic t_read_only;
		host.frame(2'h3, 8'h00, 1'h0, 11, rd);
		host.select(1'h0);
		host.select(1'h1);
		check("read only", 32'hA5, {24'h0, rd});
		check("unchanged", exp, chans);
	endtask
	task automatic t_deselected;
		host.select(1'h0);
		host.frame(2'h1, 8'hFF, 1'h0, 13, rd);
		check("ignored", exp, chans);
		host.select(1'h1);
	endtask
	initial begin
		#(40 * 20000);
		num_errors++;
		end_sim();
	end
	initial begin
		repeat (8) @(posedge clock_in);
		reset_n_in <= 1'h1;
		repeat (8) @(posedge clock_in);
		check("power up", STORE_INIT, chans);
		check("idle ready", 32'h1, {31'h0, ready});
		t_temp();
		t_program_strobe();
		t_read_only();
		t_deselected();
		end_sim();
	end
endmodule
